// ===== include/pdc_defines.svh
// Offsets, field positions, reset values and codes of the PLL divider bank
`ifndef PDC_DEFINES_SVH
`define PDC_DEFINES_SVH
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define PDC_REF_DIVIDER_OUT1_CONTROL 8'h18
`define PDC_INT_DIVIDER_HIGH 8'h19
`define PDC_INT_DIVIDER_LOW 8'h1a
`define PDC_FRAC_NUMERATOR_BYTE2 8'h1b
`define PDC_FRAC_NUMERATOR_BYTE1 8'h1c
`define PDC_FRAC_NUMERATOR_BYTE0 8'h1d
`define PDC_FRAC_DENOMINATOR_BYTE2 8'h1e
`define PDC_FRAC_DENOMINATOR_BYTE1 8'h1f
`define PDC_FRAC_DENOMINATOR_BYTE0 8'h20
`define PDC_MODULATOR_CONTROL 8'h21
`define PDC_SYNTH_CONTROL0 8'h22
// ----------------------------------------
// Field positions
// ----------------------------------------
`define PDC_TRISTATE_BIT 4
`define PDC_RDIV_BIT 0
`define PDC_DOUBLER_BIT 5
`define PDC_DITHER_LSB 2
`define PDC_ORDER_LSB 0
`define PDC_CP_LSB 0
// ----------------------------------------
// Reset values and codes
// ----------------------------------------
`define PDC_TRISTATE_RST 1'h1
`define PDC_RDIV_RST 1'h0
`define PDC_NDIV_RST 12'h032
`define PDC_NUM_RST 22'h000000
`define PDC_DEN_RST 22'h000000
`define PDC_DITHER_WEAK 2'h0
`define PDC_DITHER_OFF 2'h3
`define PDC_ORDER_INT 2'h0
`define PDC_ORDER_THIRD 2'h3
`define PDC_DOUBLER_RST 1'h1
`define PDC_CP_LOW 4'h4
`define PDC_CP_HIGH 4'h8
`endif

// ===== include/pdc_pkg.sv
// Types shared by the PLL divider bank
package pdc_pkg;
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } pdc_req_type;

  typedef struct packed {
    logic tristate;
    logic rdiv4;
    logic [11:0] ndiv;
    logic [21:0] num;
    logic [21:0] den;
    logic [1:0] dither;
    logic [1:0] order;
    logic doubler;
    logic [3:0] cp;
  } pdc_cfg_type;
endpackage

// ===== hw/pdc_regs.sv
// Byte-wide configuration register bank of the fractional-N synthesizer
`include "pdc_defines.svh"

module pdc_regs (
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic ce_in,
  input wire pdc_pkg::pdc_req_type req_in,
  output pdc_pkg::pdc_cfg_type cfg_out,
  output logic [21:0] frac_num_applied_out,
  output logic frac_active_out,
  output logic [7:0] rdata_out,
  output logic rvalid_out
);
  // ----------------------------------------
  // State
  // ----------------------------------------
  pdc_pkg::pdc_cfg_type cfg;
  pdc_pkg::pdc_cfg_type next_cfg;
  logic [21:0] frac_num_applied;
  logic frac_active;
  logic [7:0] rdata;
  logic rvalid;

  function automatic logic hit(input pdc_pkg::pdc_req_type r, input logic [7:0] a);
    hit = r.wr && (r.addr == a);
  endfunction

  // ----------------------------------------
  // Write decode
  // ----------------------------------------
  wire logic w_ctl = hit(req_in, `PDC_REF_DIVIDER_OUT1_CONTROL);
  wire logic w_nhi = hit(req_in, `PDC_INT_DIVIDER_HIGH);
  wire logic w_nlo = hit(req_in, `PDC_INT_DIVIDER_LOW);
  wire logic w_nm2 = hit(req_in, `PDC_FRAC_NUMERATOR_BYTE2);
  wire logic w_nm1 = hit(req_in, `PDC_FRAC_NUMERATOR_BYTE1);
  wire logic w_nm0 = hit(req_in, `PDC_FRAC_NUMERATOR_BYTE0);
  wire logic w_dn2 = hit(req_in, `PDC_FRAC_DENOMINATOR_BYTE2);
  wire logic w_dn1 = hit(req_in, `PDC_FRAC_DENOMINATOR_BYTE1);
  wire logic w_dn0 = hit(req_in, `PDC_FRAC_DENOMINATOR_BYTE0);
  wire logic w_mod = hit(req_in, `PDC_MODULATOR_CONTROL);
  wire logic w_syn = hit(req_in, `PDC_SYNTH_CONTROL0);
  wire logic [7:0] wd = req_in.wdata;
  wire logic [3:0] wd_cp = wd[`PDC_CP_LSB +: 4];
  // Unsupported pump codes would stress the loop, so they are dropped
  wire logic cp_ok = (wd_cp == `PDC_CP_LOW) || (wd_cp == `PDC_CP_HIGH);

  always_comb begin
    next_cfg = cfg;
    if (w_ctl) begin
      next_cfg.tristate = wd[`PDC_TRISTATE_BIT];
      next_cfg.rdiv4 = wd[`PDC_RDIV_BIT];
    end
    if (w_nhi) begin
      next_cfg.ndiv[11:8] = wd[3:0];
    end
    if (w_nlo) begin
      next_cfg.ndiv[7:0] = wd;
    end
    if (w_nm2) begin
      next_cfg.num[21:16] = wd[5:0];
    end
    if (w_nm1) begin
      next_cfg.num[15:8] = wd;
    end
    if (w_nm0) begin
      next_cfg.num[7:0] = wd;
    end
    if (w_dn2) begin
      next_cfg.den[21:16] = wd[5:0];
    end
    if (w_dn1) begin
      next_cfg.den[15:8] = wd;
    end
    if (w_dn0) begin
      next_cfg.den[7:0] = wd;
    end
    if (w_mod) begin
      next_cfg.dither = wd[`PDC_DITHER_LSB +: 2];
      next_cfg.order = wd[`PDC_ORDER_LSB +: 2];
    end
    if (w_syn) begin
      next_cfg.doubler = wd[`PDC_DOUBLER_BIT];
    end
    if (w_syn && cp_ok) begin
      next_cfg.cp = wd_cp;
    end
  end

  // ----------------------------------------
  // Read selection
  // ----------------------------------------
  // reserved bits zero
  logic [7:0] rsel;
  always_comb begin
    rsel = 8'h00;
    unique case (req_in.addr)
      `PDC_REF_DIVIDER_OUT1_CONTROL: rsel = {3'h0, cfg.tristate, 3'h0, cfg.rdiv4};
      `PDC_INT_DIVIDER_HIGH: rsel = {4'h0, cfg.ndiv[11:8]};
      `PDC_INT_DIVIDER_LOW: rsel = cfg.ndiv[7:0];
      `PDC_FRAC_NUMERATOR_BYTE2: rsel = {2'h0, cfg.num[21:16]};
      `PDC_FRAC_NUMERATOR_BYTE1: rsel = cfg.num[15:8];
      `PDC_FRAC_NUMERATOR_BYTE0: rsel = cfg.num[7:0];
      `PDC_FRAC_DENOMINATOR_BYTE2: rsel = {2'h0, cfg.den[21:16]};
      `PDC_FRAC_DENOMINATOR_BYTE1: rsel = cfg.den[15:8];
      `PDC_FRAC_DENOMINATOR_BYTE0: rsel = cfg.den[7:0];
      `PDC_MODULATOR_CONTROL: rsel = {4'h0, cfg.dither, cfg.order};
      `PDC_SYNTH_CONTROL0: rsel = {2'h0, cfg.doubler, 1'h0, cfg.cp};
      default: rsel = 8'h00;
    endcase
  end

  wire logic next_frac_active = (next_cfg.order != `PDC_ORDER_INT);
  wire logic [21:0] next_applied = next_frac_active ? next_cfg.num : 22'h000000;

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  // Reset wins over the enable so a frozen bank can still be cleared
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      cfg <= {`PDC_TRISTATE_RST, `PDC_RDIV_RST, `PDC_NDIV_RST, `PDC_NUM_RST, `PDC_DEN_RST,
              `PDC_DITHER_OFF, `PDC_ORDER_INT, `PDC_DOUBLER_RST, `PDC_CP_HIGH};
      frac_num_applied <= 22'h000000;
      frac_active <= 1'h0;
      rdata <= 8'h00;
      rvalid <= 1'h0;
    end else if (ce_in) begin
      cfg <= next_cfg;
      frac_num_applied <= next_applied;
      frac_active <= next_frac_active;
      rdata <= req_in.rd ? rsel : 8'h00;
      rvalid <= req_in.rd;
    end
  end

  assign cfg_out = cfg;
  assign frac_num_applied_out = frac_num_applied;
  assign frac_active_out = frac_active;
  assign rdata_out = rdata;
  assign rvalid_out = rvalid;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (rst_in);

  sequence wr_at(logic [7:0] a);
    ce_in && req_in.wr && (req_in.addr == a);
  endsequence

  sequence rd_at(logic [7:0] a);
    ce_in && req_in.rd && (req_in.addr == a);
  endsequence

  sequence rd_any;
    ce_in && req_in.rd;
  endsequence

  // Offsets outside the bank sit on both sides of it
  sequence rd_unmapped;
    rd_any ##0 (req_in.addr < `PDC_REF_DIVIDER_OUT1_CONTROL ||
      req_in.addr > `PDC_SYNTH_CONTROL0);
  endsequence

  // Pump codes judged from the rule, not from the filter itself
  sequence wr_pump_bad;
    wr_at(`PDC_SYNTH_CONTROL0) ##0 (wd_cp != `PDC_CP_LOW && wd_cp != `PDC_CP_HIGH);
  endsequence

  sequence wr_pump_good;
    wr_at(`PDC_SYNTH_CONTROL0) ##0 (wd_cp == `PDC_CP_LOW || wd_cp == `PDC_CP_HIGH);
  endsequence

  reset_values_a: assert property (disable iff (1'b0) rst_in |=>
    cfg.ndiv == `PDC_NDIV_RST && cfg.num == `PDC_NUM_RST && cfg.den == `PDC_DEN_RST &&
    cfg.tristate == `PDC_TRISTATE_RST && cfg.doubler == `PDC_DOUBLER_RST &&
    cfg.dither == `PDC_DITHER_OFF && cfg.order == `PDC_ORDER_INT && cfg.cp == `PDC_CP_HIGH)
    else $error("bad reset values");
  reset_rdiv_a: assert property (disable iff (1'b0) rst_in |=>
    cfg_out.rdiv4 == `PDC_RDIV_RST)
    else $error("divider select not reset");
  // Read port quiet after reset
  reset_outputs_a: assert property (disable iff (1'b0) rst_in |=>
    !rvalid_out && rdata_out == 8'h00 && !frac_active_out)
    else $error("read port or fraction not reset");

  tristate_write_a: assert property (wr_at(`PDC_REF_DIVIDER_OUT1_CONTROL) |=>
    cfg_out.tristate == $past(wd[`PDC_TRISTATE_BIT]))
    else $error("tristate bit not written");
  rdiv_write_a: assert property (wr_at(`PDC_REF_DIVIDER_OUT1_CONTROL) |=>
    cfg_out.rdiv4 == $past(wd[`PDC_RDIV_BIT]))
    else $error("rdiv bit not written");
  ndiv_high_a: assert property (wr_at(`PDC_INT_DIVIDER_HIGH) |=>
    cfg_out.ndiv[11:8] == $past(wd[3:0]) && cfg_out.ndiv[7:0] == $past(cfg.ndiv[7:0]))
    else $error("integer divider nibble wrong");
  ndiv_low_a: assert property (wr_at(`PDC_INT_DIVIDER_LOW) |=>
    cfg_out.ndiv[7:0] == $past(wd) && cfg_out.ndiv[11:8] == $past(cfg.ndiv[11:8]))
    else $error("integer divider low byte wrong");
  num_top_a: assert property (wr_at(`PDC_FRAC_NUMERATOR_BYTE2) |=>
    cfg_out.num[21:16] == $past(wd[5:0]))
    else $error("numerator top bits wrong");
  num_mid_a: assert property (wr_at(`PDC_FRAC_NUMERATOR_BYTE1) |=>
    cfg_out.num[15:8] == $past(wd))
    else $error("numerator middle byte wrong");
  num_low_a: assert property (wr_at(`PDC_FRAC_NUMERATOR_BYTE0) |=>
    cfg_out.num[7:0] == $past(wd))
    else $error("numerator low byte wrong");
  den_top_a: assert property (wr_at(`PDC_FRAC_DENOMINATOR_BYTE2) |=>
    cfg_out.den[21:16] == $past(wd[5:0]))
    else $error("denominator top bits wrong");
  den_mid_a: assert property (wr_at(`PDC_FRAC_DENOMINATOR_BYTE1) |=>
    cfg_out.den[15:8] == $past(wd))
    else $error("denominator middle byte wrong");
  den_low_a: assert property (wr_at(`PDC_FRAC_DENOMINATOR_BYTE0) |=>
    cfg_out.den[7:0] == $past(wd))
    else $error("denominator low byte wrong");
  dither_write_a: assert property (wr_at(`PDC_MODULATOR_CONTROL) |=>
    cfg_out.dither == $past(wd[`PDC_DITHER_LSB +: 2]))
    else $error("dither field wrong");
  order_write_a: assert property (wr_at(`PDC_MODULATOR_CONTROL) |=>
    cfg_out.order == $past(wd[`PDC_ORDER_LSB +: 2]))
    else $error("order field wrong");
  doubler_write_a: assert property (wr_at(`PDC_SYNTH_CONTROL0) |=>
    cfg_out.doubler == $past(wd[`PDC_DOUBLER_BIT]))
    else $error("doubler bit not written");
  cp_filter_a: assert property (wr_pump_bad |=> $stable(cfg_out.cp))
    else $error("unsupported pump code taken");
  cp_accept_a: assert property (wr_pump_good |=> cfg_out.cp == $past(wd_cp))
    else $error("supported pump code not taken");

  reserved_read_a: assert property (rd_at(`PDC_INT_DIVIDER_HIGH) |=>
    rvalid_out && rdata_out[7:4] == 4'h0)
    else $error("reserved bits not zero");
  unmapped_read_a: assert property (rd_unmapped |=> rvalid_out && rdata_out == 8'h00)
    else $error("unmapped offset read not zero");
  read_data_a: assert property (rd_at(`PDC_INT_DIVIDER_LOW) |=>
    rdata_out == $past(cfg.ndiv[7:0]))
    else $error("integer divider read wrong");
  // Every enabled read is answered
  read_pulse_a: assert property (rd_any |=> rvalid_out)
    else $error("read not answered");
  // Answer lasts until the next enabled cycle
  read_idle_a: assert property (ce_in && !req_in.rd |=> !rvalid_out && rdata_out == 8'h00)
    else $error("read answer outstayed its cycle");

  frac_gate_a: assert property (ce_in ##1 !frac_active_out |->
    frac_num_applied_out == 22'h000000)
    else $error("fraction applied in integer mode");
  frac_follow_a: assert property (frac_active_out |->
    frac_num_applied_out == cfg_out.num)
    else $error("applied numerator stale");
  order_active_a: assert property (wr_at(`PDC_MODULATOR_CONTROL) |=>
    frac_active_out == ($past(wd[1:0]) != `PDC_ORDER_INT))
    else $error("order field not honoured");
  // Enable low freezes every output
  freeze_state_a: assert property (!ce_in |=> $stable(cfg_out) && $stable(rdata_out) &&
    $stable(rvalid_out) && $stable(frac_num_applied_out))
    else $error("state moved while disabled");
endmodule // pdc_regs

// ===== test/pdc_host_model.sv
// Host side model that programs the divider bank
module pdc_host_model (
  input wire logic mclk_in,
  output pdc_pkg::pdc_req_type req_out
);
  timeunit 1ns;
  timeprecision 1ps;
  initial req_out = '0;
  task automatic put(input pdc_pkg::pdc_req_type r);
    @(posedge mclk_in);
    req_out <= r;
  endtask
  task automatic write_num(input logic [21:0] v);
    put('{wr:1'b1, rd:1'b0, addr:8'h1b, wdata:{2'h0, v[21:16]}});
    put('{wr:1'b1, rd:1'b0, addr:8'h1c, wdata:v[15:8]});
    put('{wr:1'b1, rd:1'b0, addr:8'h1d, wdata:v[7:0]});
  endtask
endmodule // pdc_host_model

// ===== test/tb.sv
// Self-checking bench of the divider bank
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin err_total++; \
  $display("BAD %s exp %h got %h", n, e, g); end end
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk_in = 1'b0;
  logic rst_in = 1'b1;
  logic ce_in = 1'b1;
  pdc_pkg::pdc_req_type req;
  pdc_pkg::pdc_cfg_type cfg;
  logic [21:0] applied;
  logic active;
  logic [7:0] rdata;
  logic rvalid;
  logic [7:0] rg [24:34];
  logic [31:0] seed = 32'h073ba76b;
  int err_total = 0;
  int checks = 0;
  int cycles = 0;
  int i;
  initial begin
    forever #4 mclk_in = ~mclk_in;
  end
  pdc_host_model u_host (.mclk_in(mclk_in), .req_out(req));
  pdc_regs u_pdc_regs (.mclk_in(mclk_in), .rst_in(rst_in), .ce_in(ce_in), .req_in(req),
    .cfg_out(cfg), .frac_num_applied_out(applied), .frac_active_out(active),
    .rdata_out(rdata), .rvalid_out(rvalid));
  function automatic logic [7:0] msk(input logic [7:0] a);
    case (a)
      8'h18: return 8'h11;
      8'h19, 8'h21: return 8'h0f;
      8'h1b, 8'h1e: return 8'h3f;
      8'h1a, 8'h1c, 8'h1d, 8'h1f, 8'h20: return 8'hff;
      8'h22: return 8'h2f;
      default: return 8'h00;
    endcase
  endfunction
  function automatic pdc_pkg::pdc_cfg_type exp_cfg();
    pdc_pkg::pdc_cfg_type c;
    c = {rg[24][4], rg[24][0], rg[25][3:0], rg[26], rg[27][5:0], rg[28], rg[29],
      rg[30][5:0], rg[31], rg[32], rg[33][3:0], rg[34][5], rg[34][3:0]};
    return c;
  endfunction
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic model_reset();
    rg = '{8'h10, 8'h00, 8'h32, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h0c, 8'h28};
  endtask
  task automatic mwr(input logic [7:0] a, input logic [7:0] d);
    u_host.put('{wr:1'b1, rd:1'b0, addr:a, wdata:d});
    if (a == 8'h22 && d[3:0] != 4'h4 && d[3:0] != 4'h8) rg[34] = {2'h0, d[5], 1'h0, rg[34][3:0]};
    else if (msk(a) != 8'h00) rg[a] = d & msk(a);
  endtask
  task automatic check_all();
    pdc_pkg::pdc_cfg_type c;
    logic [7:0] a;
    c = exp_cfg();
    u_host.put('0);
    #1;
    `CHK("cfg", c, cfg)
    `CHK("applied", (c.order != 2'h0) ? c.num : 22'h0, applied)
    `CHK("active", c.order != 2'h0, active)
    for (a = 8'h17; a <= 8'h23; a++) begin
      u_host.put('{wr:1'b0, rd:1'b1, addr:a, wdata:8'h00});
      u_host.put('0);
      #1;
      `CHK("rvalid", 1'b1, rvalid)
      `CHK("rdata", (msk(a) != 8'h00) ? rg[a] & msk(a) : 8'h00, rdata)
    end
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // Hang guard, well above the expected run length
  always @(posedge mclk_in) begin
    cycles++;
    if (cycles == 40000) begin
      err_total++;
      complete_run();
    end
  end
  initial begin
    model_reset();
    repeat (20) @(posedge mclk_in);
    rst_in <= 1'b0;
    check_all();
    $display("test reset values done");
    for (i = 0; i < 16; i++) begin
      mwr(8'h21, {4'ha, i[3:0]});
      check_all();
    end
    $display("test dither order codes done");
    for (i = 0; i < 16; i++) begin
      mwr(8'h22, {2'h3, i[0], 1'h1, i[3:0]});
      check_all();
    end
    $display("test pump codes done");
    u_host.write_num(22'h2a5c3e);
    rg[27] = 8'h2a;
    rg[28] = 8'h5c;
    rg[29] = 8'h3e;
    mwr(8'h1e, 8'hff);
    mwr(8'h1f, 8'h81);
    mwr(8'h20, 8'h7e);
    mwr(8'h19, 8'hfa);
    mwr(8'h1a, 8'h01);
    mwr(8'h21, 8'h03);
    check_all();
    $display("test fraction done");
    repeat (300) begin
      seed = lfsr(seed);
      mwr(8'h16 + {4'h0, seed[3:0]}, seed[15:8]);
      if (seed[16]) check_all();
    end
    check_all();
    $display("test random writes done");
    // Frozen state must ignore a write
    @(posedge mclk_in) ce_in <= 1'b0;
    u_host.put('{wr:1'b1, rd:1'b0, addr:8'h1a, wdata:8'h77});
    u_host.put('0);
    @(posedge mclk_in) ce_in <= 1'b1;
    check_all();
    u_host.put('{wr:1'b1, rd:1'b1, addr:8'h1a, wdata:8'h5a});
    u_host.put('0);
    #1;
    `CHK("old read", rg[26], rdata)
    rg[26] = 8'h5a;
    check_all();
    $display("test enable and overlap done");
    @(posedge mclk_in) rst_in <= 1'b1;
    @(posedge mclk_in) rst_in <= 1'b0;
    model_reset();
    check_all();
    $display("test second reset done");
    complete_run();
  end
endmodule // tb
